// >>> sadc_control.sv
// sadc_control: register file, clock selection and successive-approximation sequencer of the converter.
// assumes an AHB-Lite master on hclk, a comparator strobed on hclk, and a free RC oscillator on rc_osc_in.
//
// Behaviour
// - set done flag when conversion finishes
// - any control write clears flag, starts conversion if enable is set
// - reading result register clears done flag
// - keep converting every 32 ticks until rewritten
// - each conversion overwrites result, sets flag
// - rc select picks oscillator else bus clock
// - rc select and enable act independently
// - enable powers converter and charge pump
// - four-bit channel field picks eleven sources, 10..15 all low ref
// - channel map: temp, pins, supply, references
// - result loads with the flag set
// - wait mode changes nothing
// - stop disables analog and aborts conversion
// - stop keeps both registers unchanged
// - sample switch closed at most 12 cycles
// - reset clears rc select and enable
// - control write aborts running conversion
// - full scale saturates at FF, low ref zero
// - results move to register on bus clock
`timescale 1ns/1ps
`default_nettype none

module sadc_control
    import sadc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        rc_osc_in,
    input  wire logic        comp_above,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output var  logic        rc_osc_enable,
    output var  logic        charge_pump_enable,
    output var  logic        comparator_enable,
    output var  logic        sample_switch,
    output var  logic [7:0]  dac_code,
    output var  logic [2:0]  source_select,
    output var  logic [2:0]  pin_select
);

    logic [7:0]  conv_status_control;
    logic [6:0]  ctl_fields;
    logic        done_flag;
    logic        next_done_flag;
    logic [7:0]  conv_result;
    logic        ph_write_ctl;
    logic        rd_result;
    logic        wr_ctl;
    logic        addr_valid;
    logic        rc_sync1;
    logic        rc_sync2;
    logic        rc_prev;
    logic        conv_tick;
    logic        running;
    logic        active;
    sadc_state_t state;
    logic [4:0]  step;
    logic [3:0]  sample_cnt;
    logic [7:0]  sar;
    logic [7:0]  next_sar;
    logic        conv_finish;
    logic [2:0]  bit_idx;
    logic [4:0]  sar_ofs;

    // the slave never stretches a transfer and never reports an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign addr_valid = hsel && hready && (htrans == SADC_HTRANS_NONSEQ || htrans == SADC_HTRANS_SEQ);
    assign rd_result  = addr_valid && !hwrite && haddr == SADC_OFS_RESULT;
    assign wr_ctl     = ph_write_ctl;

    // remember a control write for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write_ctl <= 1'b0;
        end else begin
            ph_write_ctl <= addr_valid && hwrite && haddr == SADC_OFS_STATUS_CONTROL;
        end
    end

    // read data is latched at the address phase so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_valid && !hwrite) begin
            case (haddr)
                SADC_OFS_STATUS_CONTROL: hrdata <= {24'h000000, conv_status_control};
                SADC_OFS_RESULT:         hrdata <= {24'h000000, conv_result};
                default:                 hrdata <= 32'h00000000;
            endcase
        end
    end

    // control fields; the done flag position ignores written data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_fields <= SADC_STATUS_CONTROL_RST[6:0];
        end else if (wr_ctl) begin
            ctl_fields <= hwdata[6:0];
        end
    end

    // flag and fields live apart so each flop has a single writer
    assign conv_status_control = {done_flag, ctl_fields};

    // done flag: a finishing conversion wins over a result read in the same cycle
    always_comb begin
        next_done_flag = done_flag;
        if (wr_ctl) begin
            next_done_flag = 1'b0;
        end else if (conv_finish) begin
            next_done_flag = 1'b1;
        end else if (rd_result) begin
            next_done_flag = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag <= SADC_STATUS_CONTROL_RST[SADC_BIT_DONE_FLAG];
        end else begin
            done_flag <= next_done_flag;
        end
    end

    // result loads in the same edge that sets the flag, old value overwritten regardless
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_result <= SADC_RESULT_RST;
        end else if (conv_finish) begin
            conv_result <= sar;
        end
    end

    // oscillator pin is asynchronous: two flops, then an edge detector on the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_sync1 <= 1'b0;
            rc_sync2 <= 1'b0;
            rc_prev  <= 1'b0;
        end else begin
            rc_sync1 <= rc_osc_in;
            rc_sync2 <= rc_sync1;
            rc_prev  <= rc_sync2;
        end
    end

    // the oscillator must run slower than half of hclk to be seen; slower ticks are simply fewer
    assign conv_tick = conv_status_control[SADC_BIT_RC_SELECT] ? (rc_sync2 && !rc_prev) : 1'b1;

    // stop aborts; wait_mode is deliberately not looked at
    assign active = running && conv_status_control[SADC_BIT_ENABLE] && !stop_mode;

    // a control write arms continuous conversion until the next write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running <= 1'b0;
        end else if (wr_ctl) begin
            running <= 1'b1;
        end
    end

    assign conv_finish = active && conv_tick && step == SADC_CONV_LAST && !wr_ctl;
    assign sar_ofs     = step - SADC_SAR_FIRST;
    assign bit_idx     = 3'(3'h7 - sar_ofs[2:0]);

    // sequencer: step counts conversion ticks, sampling at the head of each conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= SADC_ST_IDLE;
            step  <= 5'h00;
        end else if (wr_ctl || !active) begin
            state <= SADC_ST_IDLE;
            step  <= 5'h00;
        end else begin
            case (state)
                SADC_ST_IDLE: begin
                    state <= SADC_ST_SAMPLE;
                    step  <= 5'h00;
                end
                SADC_ST_SAMPLE: begin
                    if (conv_tick) begin
                        step <= step + 5'h01;
                        if (step == SADC_SAR_START) begin
                            state <= SADC_ST_CONV;
                        end
                    end
                end
                SADC_ST_CONV: begin
                    if (conv_tick) begin
                        if (step == SADC_CONV_LAST) begin
                            state <= SADC_ST_SAMPLE;
                            step  <= 5'h00;
                        end else begin
                            step <= step + 5'h01;
                        end
                    end
                end
                default: begin
                    state <= SADC_ST_IDLE;
                    step  <= 5'h00;
                end
            endcase
        end
    end

    // bus-cycle counter bounds the sample window even when ticks are slow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_cnt <= 4'h0;
        end else if (state != SADC_ST_SAMPLE || wr_ctl || !active) begin
            sample_cnt <= 4'h0;
        end else if (sample_cnt != SADC_SAMPLE_CYC) begin
            sample_cnt <= sample_cnt + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_switch <= 1'b0;
        end else begin
            sample_switch <= active && !wr_ctl && state == SADC_ST_SAMPLE
                             && sample_cnt < SADC_SAMPLE_CYC - 4'h1;
        end
    end

    // successive approximation; comparator is strobed on hclk so no synchroniser is needed
    // the trial word is computed once so sar and dac_code always hold the same value
    always_comb begin
        next_sar = sar;
        if (wr_ctl || !active) begin
            next_sar = 8'h00;
        end else if (conv_tick && state == SADC_ST_SAMPLE && step == SADC_SAR_START) begin
            next_sar = SADC_SAR_TOP;
        end else if (conv_tick && state == SADC_ST_CONV && step >= SADC_SAR_FIRST && step <= SADC_SAR_LAST) begin
            // all ones at or above the high reference, no overflow bit
            next_sar[bit_idx] = comp_above;
            if (bit_idx != 3'h0) begin
                next_sar[bit_idx - 3'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sar <= 8'h00;
        end else begin
            sar <= next_sar;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= 8'h00;
        end else begin
            // a copy lagging sar would let each decision judge the previous trial
            dac_code <= next_sar;
        end
    end

    // analog power; stop overrides all three enables, the register bits stay as written
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_osc_enable      <= 1'b0;
            charge_pump_enable <= 1'b0;
            comparator_enable  <= 1'b0;
        end else begin
            rc_osc_enable      <= conv_status_control[SADC_BIT_RC_SELECT] && !stop_mode;
            charge_pump_enable <= conv_status_control[SADC_BIT_ENABLE] && !stop_mode;
            comparator_enable  <= conv_status_control[SADC_BIT_ENABLE] && !stop_mode;
        end
    end

    // channel decode; channel 0 and 7..15 are internal only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            source_select <= SADC_SRC_TEMP;
            pin_select    <= 3'h0;
        end else begin
            pin_select <= 3'h0;
            case (conv_status_control[SADC_CHAN_MSB:0])
                4'h0: source_select <= SADC_SRC_TEMP;
                4'h1: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h1;
                end
                4'h2: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h2;
                end
                4'h3: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h3;
                end
                4'h4: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h4;
                end
                4'h5: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h5;
                end
                4'h6: begin
                    source_select <= SADC_SRC_PIN;
                    pin_select    <= 3'h6;
                end
                4'h7: source_select <= SADC_SRC_SUPPLY;
                4'h8: source_select <= SADC_SRC_HIGH_REF;
                4'h9: source_select <= SADC_SRC_MID_REF;
                default: source_select <= SADC_SRC_LOW_REF;
            endcase
        end
    end

endmodule : sadc_control

`default_nettype wire

// >>> sadc_control_sva.sv
// sadc_control_sva: port-level checks of the converter control block.
// assumes one hclk domain and the asynchronous active-low hresetn.
`timescale 1ns/1ps
`default_nettype none
module sadc_control_sva
    import sadc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        stop_mode,
    input wire logic        rc_osc_enable,
    input wire logic        charge_pump_enable,
    input wire logic        comparator_enable,
    input wire logic        sample_switch,
    input wire logic [2:0]  source_select,
    input wire logic [2:0]  pin_select
);
    logic [3:0] samp_run;
    logic       rd_take;
    // counts high cycles so far; a stuck switch fails long before the count wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) samp_run <= 4'h0;
        else samp_run <= sample_switch ? samp_run + 4'h1 : 4'h0;
    end
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_SAMPLE_MAX: assert property (sample_switch |-> samp_run < 4'hC)
        else $error("sample switch closed too long");
    AST_PUMP_PAIR: assert property (charge_pump_enable == comparator_enable)
        else $error("charge pump and comparator enables differ");
    AST_STOP_OFF: assert property (stop_mode |=> !charge_pump_enable && !comparator_enable
        && !rc_osc_enable)
        else $error("analog left on in stop");
    AST_STOP_IDLE: assert property (stop_mode ##1 stop_mode |=> !sample_switch)
        else $error("sampling during stop");
    AST_STOP_HOLD: assert property (stop_mode && $past(stop_mode) |-> $stable(source_select)
        && $stable(pin_select))
        else $error("channel changed during stop");
    AST_RD_BYTE: assert property (rd_take |=> hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_UNMAPPED: assert property (rd_take && haddr != 8'h00 && haddr != 8'h04 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_PIN_MAP: assert property (source_select == 3'h1 |-> pin_select inside {[3'h1:3'h6]})
        else $error("pin number out of range");
    AST_NONPIN: assert property (source_select != 3'h1 |-> pin_select == 3'h0)
        else $error("pin number without pin source");
    AST_SRC_RANGE: assert property (source_select <= 3'h5)
        else $error("source code out of range");
endmodule : sadc_control_sva
bind sadc_control sadc_control_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .stop_mode(stop_mode),
    .rc_osc_enable(rc_osc_enable), .charge_pump_enable(charge_pump_enable), .comparator_enable(comparator_enable),
    .sample_switch(sample_switch), .source_select(source_select), .pin_select(pin_select));
`default_nettype wire

// >>> sadc_pkg.sv
// sadc_pkg: constants, register map and types of the 8-bit SAR converter control block.
// assumes the single bus clock hclk at 10 MHz; all counts are in cycles of that clock or of conversion ticks.
package sadc_pkg;

    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] SADC_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] SADC_OFS_RESULT         = 8'h04;

    // conv_status_control field positions
    localparam int SADC_BIT_DONE_FLAG  = 7;
    localparam int SADC_BIT_RC_SELECT  = 6;
    localparam int SADC_BIT_ENABLE     = 5;
    localparam int SADC_BIT_TEST       = 4;
    localparam int SADC_CHAN_MSB       = 3;

    // values after reset
    localparam logic [7:0] SADC_STATUS_CONTROL_RST = 8'h00;
    localparam logic [7:0] SADC_RESULT_RST         = 8'h00;

    // conversion timing, in conversion ticks unless noted
    localparam logic [4:0] SADC_CONV_LAST    = 5'h1F;  // 32 ticks per conversion
    localparam logic [4:0] SADC_SAR_START    = 5'h0B;  // trial of the top bit is set here
    localparam logic [4:0] SADC_SAR_FIRST    = 5'h0C;  // first bit decision
    localparam logic [4:0] SADC_SAR_LAST     = 5'h13;  // last bit decision
    localparam logic [7:0] SADC_SAR_TOP      = 8'h80;
    // sampling window: 12 bus clock cycles at most
    localparam int         SADC_SAMPLE_NS    = 1200;
    localparam int         SADC_CLK_NS       = 100;
    localparam logic [3:0] SADC_SAMPLE_CYC   = 4'((SADC_SAMPLE_NS) / SADC_CLK_NS);

    // AHB-Lite encodings
    localparam logic [1:0] SADC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SADC_HTRANS_SEQ    = 2'h3;

    // what the analog multiplexer routes to the sampler
    typedef enum logic [2:0] {
        SADC_SRC_TEMP     = 3'b000,
        SADC_SRC_PIN      = 3'b001,
        SADC_SRC_SUPPLY   = 3'b010,
        SADC_SRC_HIGH_REF = 3'b011,
        SADC_SRC_MID_REF  = 3'b100,
        SADC_SRC_LOW_REF  = 3'b101
    } sadc_source_t;

    // conversion sequencer states
    typedef enum logic [1:0] {
        SADC_ST_IDLE   = 2'b00,
        SADC_ST_SAMPLE = 2'b01,
        SADC_ST_CONV   = 2'b10
    } sadc_state_t;

endpackage : sadc_pkg

// >>> tb_top.sv
// tb_top: self-checking bench of sadc_control through its AHB-Lite slave.
// assumes a 10 MHz hclk; the bench plays comparator, rc oscillator and power modes.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sadc_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        rc_osc_in = 1'b0;
    logic        rc_run = 1'b0;
    logic [1:0]  rc_div = 2'h0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic [7:0]  ofs = 8'h00;
    logic [7:0]  ain;
    logic        hreadyout, hresp, rc_osc_enable, charge_pump_enable, comparator_enable, sample_switch;
    logic [31:0] hrdata;
    logic [7:0]  dac_code;
    logic [2:0]  source_select, pin_select;
    wire logic   hready;
    wire logic   comp_above;
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          t0, t1;
    assign hready = hreadyout;
    // analog level per source; high and low references pinned to full scale and zero
    // pins are driven straight, as inputs with pull-ups off
    assign ain = (source_select == 3'h3) ? 8'hFF :
                 (source_select == 3'h5) ? 8'h00 : {source_select, pin_select, 2'h2} ^ ofs;
    assign comp_above = (ain >= dac_code);
    sadc_control i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rc_osc_in(rc_osc_in), .comp_above(comp_above), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .rc_osc_enable(rc_osc_enable), .charge_pump_enable(charge_pump_enable),
        .comparator_enable(comparator_enable), .sample_switch(sample_switch), .dac_code(dac_code),
        .source_select(source_select), .pin_select(pin_select));
    always #50 hclk = ~hclk;
    // oscillator stands still unless a test runs it, period six bus cycles
    always @(posedge hclk) begin
        rc_div <= (rc_div == 2'h2) ? 2'h0 : rc_div + 2'h1;
        if (rc_div == 2'h2) rc_osc_in <= rc_run & ~rc_osc_in;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            stop_test;
        end
    end
    function automatic logic [7:0] code(input logic [3:0] ch, input logic [7:0] o);
        if (ch == 4'h8) return 8'hFF;
        if (ch > 4'h9) return 8'h00;
        if (ch == 4'h0) return 8'h02 ^ o;
        if (ch == 4'h7) return 8'h42 ^ o;
        if (ch == 4'h9) return 8'h82 ^ o;
        return {3'h1, ch[2:0], 2'h2} ^ o;
    endfunction : code
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= SADC_HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] junk;
        bus(a, 1'b1, d, junk);
        t0 = cyc;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        bus(a, 1'b0, 8'h00, v);
        chk(v, {24'h0, e});
    endtask : rdc
    task automatic wait_to(input int t);
        while (cyc < t) @(posedge hclk);
    endtask : wait_to
    task automatic test_reset;
        chk(hreadyout, 1'b1);
        chk(hresp, 1'b0);
        rdc(SADC_OFS_STATUS_CONTROL, 8'h00);
        rdc(SADC_OFS_RESULT, 8'h00);
        rdc(8'h08, 8'h00);
        chk(rc_osc_enable, 1'b0);
        chk(charge_pump_enable, 1'b0);
        $display("test reset done");
    endtask : test_reset
    task automatic test_channels;
        for (int i = 0; i < 16; i++) begin
            wr(SADC_OFS_STATUS_CONTROL, 8'hA0 | 8'(i)); // flag position set, test bit kept zero
            rdc(SADC_OFS_STATUS_CONTROL, 8'h20 | 8'(i));
            wait_to(t0 + 31);
            rdc(SADC_OFS_STATUS_CONTROL, 8'h20 | 8'(i));
            wait_to(t0 + 36);
            rdc(SADC_OFS_STATUS_CONTROL, 8'hA0 | 8'(i));
            rdc(SADC_OFS_RESULT, code(4'(i), 8'h00));
            rdc(SADC_OFS_STATUS_CONTROL, 8'h20 | 8'(i));
        end
        $display("test channels done");
    endtask : test_channels
    task automatic test_cont_abort;
        wr(SADC_OFS_STATUS_CONTROL, 8'h21);
        wait_to(t0 + 36);
        rdc(SADC_OFS_RESULT, code(4'h1, 8'h00));
        ofs <= 8'h01;
        wait_to(t0 + 62);
        rdc(SADC_OFS_STATUS_CONTROL, 8'h21);
        wait_to(t0 + 70);
        rdc(SADC_OFS_STATUS_CONTROL, 8'hA1);
        wr(SADC_OFS_STATUS_CONTROL, 8'h22);
        t1 = t0;
        rdc(SADC_OFS_STATUS_CONTROL, 8'h22);
        wait_to(t1 + 20);
        wr(SADC_OFS_STATUS_CONTROL, 8'h23);
        wait_to(t1 + 36);
        rdc(SADC_OFS_STATUS_CONTROL, 8'h23);
        wait_to(t0 + 36);
        rdc(SADC_OFS_STATUS_CONTROL, 8'hA3);
        rdc(SADC_OFS_RESULT, code(4'h3, 8'h01));
        $display("test continuous and abort done");
    endtask : test_cont_abort
    task automatic test_modes;
        ofs <= 8'h00;
        wait_mode <= 1'b1;
        wr(SADC_OFS_STATUS_CONTROL, 8'h24);
        // switch closes on the second edge after the write and stays 11 cycles
        wait_to(t0 + 3);
        chk(sample_switch, 1'b1);
        wait_to(t0 + 13);
        chk(sample_switch, 1'b1);
        wait_to(t0 + 14);
        chk(sample_switch, 1'b0);
        wait_to(t0 + 36);
        rdc(SADC_OFS_STATUS_CONTROL, 8'hA4);
        rdc(SADC_OFS_RESULT, code(4'h4, 8'h00));
        // stop lands mid conversion so the abort shows as a missing flag
        wait_to(t0 + 48);
        stop_mode <= 1'b1;
        ofs <= 8'h03;
        repeat (40) @(posedge hclk);
        chk(charge_pump_enable, 1'b0);
        chk(comparator_enable, 1'b0);
        rdc(SADC_OFS_STATUS_CONTROL, 8'h24);
        rdc(SADC_OFS_RESULT, code(4'h4, 8'h00));
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        repeat (45) @(posedge hclk);
        rdc(SADC_OFS_STATUS_CONTROL, 8'hA4);
        rdc(SADC_OFS_RESULT, code(4'h4, 8'h03));
        $display("test wait and stop done");
    endtask : test_modes
    task automatic test_rc;
        ofs <= 8'h00;
        wr(SADC_OFS_STATUS_CONTROL, 8'h61);
        wait_to(t0 + 40);
        chk(rc_osc_enable, 1'b1);
        rdc(SADC_OFS_STATUS_CONTROL, 8'h61);
        rc_run <= 1'b1;
        repeat (260) @(posedge hclk);
        rdc(SADC_OFS_STATUS_CONTROL, 8'hE1);
        rdc(SADC_OFS_RESULT, code(4'h1, 8'h00));
        rc_run <= 1'b0;
        wr(SADC_OFS_STATUS_CONTROL, 8'h40);
        repeat (2) @(posedge hclk);
        chk(rc_osc_enable, 1'b1);
        chk(charge_pump_enable, 1'b0);
        wr(SADC_OFS_STATUS_CONTROL, 8'h00); // powered down before wait
        wait_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(rc_osc_enable, 1'b0);
        chk(comparator_enable, 1'b0);
        chk(hresp, 1'b0);
        $display("test rc clock done");
    endtask : test_rc
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        test_reset;
        test_channels;
        test_cont_abort;
        test_modes;
        test_rc;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
